// file: rtl/tmr_pkg.sv
/*
 * Package for the timer control/status register slice: register indexes,
 * control bit positions, status layout and reset values.
 * Assumes a 32-bit Avalon-MM slave with one register per aligned word.
 */
package tmr_pkg;
    // printed offsets are not multiples of four: these are indexes, byte address = 4 * index
    localparam logic [7:0] IDX_CONTROL = 8'hc8;
    localparam logic [7:0] IDX_MODE = 8'hc9;
    localparam logic [7:0] IDX_RELOAD_LO = 8'hca;
    localparam logic [7:0] IDX_RELOAD_HI = 8'hcb;
    localparam logic [7:0] IDX_COUNT_LO = 8'hcc;
    localparam logic [7:0] IDX_COUNT_HI = 8'hcd;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hd0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hd1;
    localparam logic [7:0] IDX_BIT_SET = 8'hd2;
    localparam logic [7:0] IDX_BIT_CLR = 8'hd3;

    localparam int B_OVF = 7;
    localparam int B_EXT = 6;
    localparam int B_RXCLK = 5;
    localparam int B_TXCLK = 4;
    localparam int B_EXTEN = 3;
    localparam int B_RUN = 2;
    localparam int B_CSEL = 1;
    localparam int B_CPRL = 0;

    // mode register bits kept here: direction enable and dual-slope select
    localparam int M_DIRECTION_COUNT_ENABLE = 0;
    localparam int M_DUAL = 1;

    // interrupt status bits
    localparam int S_OVF = 0;
    localparam int S_EXT = 1;
    localparam int S_CAP = 2;
    localparam int S_RELOAD = 3;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [3:0] IRQ_RESET = 4'h0;
endpackage : tmr_pkg

// file: rtl/tmr_sync.sv
/*
 * Two-flop synchroniser bank for pin inputs.
 * Assumes inputs are asynchronous to i_clk.
 */
`timescale 1ns/1ps
module tmr_sync #(
    parameter int W = 2
) (
    input wire logic i_clk,           // system clock
    input wire logic i_resetn,        // sync reset, active low
    input wire logic [W-1:0] i_async, // raw pins
    output logic [W-1:0] o_sync       // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } tmr_sync_s;
    tmr_sync_s r_q;
    tmr_sync_s r_d;

    always_comb begin
        r_d = r_q;
        r_d.meta = i_async;
        r_d.stable = r_q.meta;
    end

    // pins idle high
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            r_q <= '{meta: {W{1'b1}}, stable: {W{1'b1}}};
        end else begin
            r_q <= r_d;
        end
    end

    assign o_sync = r_q.stable;
endmodule : tmr_sync

// file: rtl/tmr_core.sv
/*
 * 16-bit timer/counter register slice: count, capture/reload, control/status,
 * a mode register, serial clock routing and a masked interrupt, on Avalon-MM.
 * Assumes the event and capture pins are asynchronous; one 100 MHz clock.
 */
`timescale 1ns/1ps
// What this block does
// - count exposed as high byte at index cd, low byte at cc
// - capture/reload value exposed as high byte cb, low byte ca
// - eight-bit control/status register, bit writable, resets to zero
// - overflow sets overflow flag; only software clears it
// - no overflow flag while either serial clock select is one
// - external flag set on enabled falling-edge capture or reload
// - set external flag requests the timer interrupt when enabled
// - external flag stays set until software clears it
// - external flag gives no timer vector request in up/down or dual-slope mode
// - run bit one starts the timer, zero stops it
// - counter select picks clock cycles or external falling edges
// - capture on external edge, or reload on overflow or external edge
// - serial clock select forces auto-reload on each overflow
module tmr_core (
    input wire logic i_clk,                 // 100 MHz system clock
    input wire logic i_resetn,              // sync reset, active low
    input wire logic [9:0] i_avs_address,   // byte address
    input wire logic i_avs_read,            // read request
    input wire logic i_avs_write,           // write request
    input wire logic [31:0] i_avs_writedata, // write data
    input wire logic [3:0] i_avs_byteenable, // byte lanes
    output logic [31:0] o_avs_readdata,     // read data
    output logic o_avs_waitrequest,         // stall
    input wire logic i_event_pin,           // external event input
    input wire logic i_capture_pin,         // external capture/reload input
    input wire logic i_timer_irq_enable,    // timer interrupt enable from interrupt controller
    output logic o_irq,                     // masked interrupt, level
    output logic o_timer_vector_req,        // timer vector request, level
    output logic o_serial_rx_clock,         // overflow pulse as receive clock
    output logic o_serial_tx_clock          // overflow pulse as transmit clock
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [15:0] count;
        logic [15:0] reload;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic ev_prev;
        logic cap_prev;
        logic ack;
        logic [31:0] rdata;
        logic irq;
        logic vec;
        logic rx_clk;
        logic tx_clk;
    } tmr_core_s;

    tmr_core_s r_q;
    tmr_core_s r_d;
    logic [1:0] pins_sync;

    tmr_sync #(.W(2)) u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_async({i_capture_pin, i_event_pin}),
        .o_sync(pins_sync)
    );

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd, input logic lane);
        merge_byte = lane ? wd[7:0] : old;
    endfunction : merge_byte

    logic [7:0] idx;
    logic req;
    logic wr_hit;
    logic rd_hit;
    logic ser_sel;
    logic tick;
    logic ovf;
    logic ext_fall;
    logic ext_act;
    logic [7:0] wbyte;
    logic [7:0] hw_set;
    logic ext_irq_ok;

    always_comb begin
        r_d = r_q;
        idx = i_avs_address[9:2];
        req = (i_avs_read || i_avs_write) && !r_q.ack;
        wr_hit = req && i_avs_write;
        rd_hit = req && i_avs_read;
        wbyte = i_avs_writedata[7:0];
        ser_sel = r_q.ctrl[tmr_pkg::B_RXCLK] || r_q.ctrl[tmr_pkg::B_TXCLK];
        tick = r_q.ctrl[tmr_pkg::B_CSEL] ? (r_q.ev_prev && !pins_sync[0]) : 1'b1;
        tick = tick && r_q.ctrl[tmr_pkg::B_RUN];
        ovf = tick && (r_q.count == tmr_pkg::COUNT_MAX);
        ext_fall = r_q.cap_prev && !pins_sync[1];
        ext_act = ext_fall && r_q.ctrl[tmr_pkg::B_EXTEN] && !ser_sel;
        r_d.ev_prev = pins_sync[0];
        r_d.cap_prev = pins_sync[1];
        r_d.rx_clk = 1'b0;
        r_d.tx_clk = 1'b0;
        hw_set = 8'h00;

        // counting datapath
        if (tick) begin
            r_d.count = r_q.count + 16'h0001;
        end
        // reload on overflow in reload mode, forced in serial clock mode
        if (ovf && (ser_sel || !r_q.ctrl[tmr_pkg::B_CPRL])) begin
            r_d.count = r_q.reload;
        end
        if (ext_act) begin
            if (r_q.ctrl[tmr_pkg::B_CPRL]) begin
                r_d.reload = r_q.count;
            end else begin
                r_d.count = r_q.reload;
            end
            hw_set[tmr_pkg::B_EXT] = 1'b1;
        end
        if (ovf && !ser_sel) begin
            hw_set[tmr_pkg::B_OVF] = 1'b1;
        end
        r_d.rx_clk = ovf && r_q.ctrl[tmr_pkg::B_RXCLK];
        r_d.tx_clk = ovf && r_q.ctrl[tmr_pkg::B_TXCLK];

        // register writes; software writes lose to hardware sets below
        r_d.ack = 1'b0;
        if (req) begin
            r_d.ack = 1'b1;
        end
        if (wr_hit && i_avs_byteenable[0]) begin
            case (idx)
                tmr_pkg::IDX_CONTROL: r_d.ctrl = wbyte;
                tmr_pkg::IDX_MODE: r_d.mode = wbyte & 8'h03;
                tmr_pkg::IDX_RELOAD_LO: r_d.reload[7:0] = merge_byte(r_q.reload[7:0], i_avs_writedata, 1'b1);
                tmr_pkg::IDX_RELOAD_HI: r_d.reload[15:8] = merge_byte(r_q.reload[15:8], i_avs_writedata, 1'b1);
                tmr_pkg::IDX_COUNT_LO: r_d.count[7:0] = wbyte;
                tmr_pkg::IDX_COUNT_HI: r_d.count[15:8] = wbyte;
                tmr_pkg::IDX_IRQ_MASK: r_d.irq_mask = wbyte[3:0];
                tmr_pkg::IDX_BIT_SET: r_d.ctrl = r_q.ctrl | wbyte;
                tmr_pkg::IDX_BIT_CLR: r_d.ctrl = r_q.ctrl & ~wbyte;
                default: r_d.ctrl = r_d.ctrl;
            endcase
        end
        r_d.ctrl = r_d.ctrl | hw_set;
        // no hardware clear of the external flag

        // interrupt status: read clears, new events win
        if (rd_hit && idx == tmr_pkg::IDX_IRQ_STATUS) begin
            r_d.irq_status = tmr_pkg::IRQ_RESET;
        end
        r_d.irq_status[tmr_pkg::S_OVF] = r_d.irq_status[tmr_pkg::S_OVF] | hw_set[tmr_pkg::B_OVF];
        r_d.irq_status[tmr_pkg::S_EXT] = r_d.irq_status[tmr_pkg::S_EXT] | hw_set[tmr_pkg::B_EXT];
        r_d.irq_status[tmr_pkg::S_CAP] = r_d.irq_status[tmr_pkg::S_CAP]
            | (ext_act && r_q.ctrl[tmr_pkg::B_CPRL]);
        r_d.irq_status[tmr_pkg::S_RELOAD] = r_d.irq_status[tmr_pkg::S_RELOAD]
            | (ovf && (ser_sel || !r_q.ctrl[tmr_pkg::B_CPRL])) | (ext_act && !r_q.ctrl[tmr_pkg::B_CPRL]);
        r_d.irq = |(r_q.irq_status & r_q.irq_mask);

        // external flag masked in up/down or dual-slope
        ext_irq_ok = !r_q.mode[tmr_pkg::M_DIRECTION_COUNT_ENABLE] && !r_q.mode[tmr_pkg::M_DUAL];
        r_d.vec = i_timer_irq_enable && (r_q.ctrl[tmr_pkg::B_OVF] || (r_q.ctrl[tmr_pkg::B_EXT] && ext_irq_ok));

        // read data registered, answered on the second cycle
        r_d.rdata = 32'h0000_0000;
        if (rd_hit) begin
            case (idx)
                tmr_pkg::IDX_CONTROL: r_d.rdata[7:0] = r_q.ctrl;
                tmr_pkg::IDX_MODE: r_d.rdata[7:0] = r_q.mode;
                tmr_pkg::IDX_RELOAD_LO: r_d.rdata[7:0] = r_q.reload[7:0];
                tmr_pkg::IDX_RELOAD_HI: r_d.rdata[7:0] = r_q.reload[15:8];
                tmr_pkg::IDX_COUNT_LO: r_d.rdata[7:0] = r_q.count[7:0];
                tmr_pkg::IDX_COUNT_HI: r_d.rdata[7:0] = r_q.count[15:8];
                tmr_pkg::IDX_IRQ_STATUS: r_d.rdata[3:0] = r_q.irq_status;
                tmr_pkg::IDX_IRQ_MASK: r_d.rdata[3:0] = r_q.irq_mask;
                tmr_pkg::IDX_BIT_SET: r_d.rdata[7:0] = r_q.ctrl;
                tmr_pkg::IDX_BIT_CLR: r_d.rdata[7:0] = r_q.ctrl;
                default: r_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            r_q <= '0;
            r_q.ctrl <= tmr_pkg::CONTROL_RESET;
            r_q.count <= tmr_pkg::COUNT_RESET;
            r_q.reload <= tmr_pkg::COUNT_RESET;
            r_q.ev_prev <= 1'b1;
            r_q.cap_prev <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_avs_readdata = r_q.rdata;
    assign o_avs_waitrequest = !r_q.ack;
    assign o_irq = r_q.irq;
    assign o_timer_vector_req = r_q.vec;
    assign o_serial_rx_clock = r_q.rx_clk;
    assign o_serial_tx_clock = r_q.tx_clk;
endmodule : tmr_core

// file: sim/tmr_core_monitor.sv
/* checker for tmr_core: bus handshake, read data and output relations.
   sees only tmr_core ports; bound at the foot of this file. */
`timescale 1ns/1ps
module tmr_core_monitor (
    input wire logic i_clk, // clock
    input wire logic i_resetn, // sync reset, active low
    input wire logic i_avs_read, // read request
    input wire logic i_avs_write, // write request
    input wire logic [31:0] o_avs_readdata, // read data
    input wire logic o_avs_waitrequest, // stall
    input wire logic i_timer_irq_enable, // vector enable
    input wire logic o_irq, // interrupt
    input wire logic o_timer_vector_req, // vector request
    input wire logic o_serial_rx_clock, // rx clock
    input wire logic o_serial_tx_clock // tx clock
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_req;
        $rose(i_avs_read) || $rose(i_avs_write);
    endsequence
    sequence s_ack;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    a_req_ack_next: assert property (s_req |=> s_ack) else $error("no one-cycle answer");
    a_idle_no_ack: assert property (!i_avs_read && !i_avs_write |=> o_avs_waitrequest)
        else $error("answer without request");
    a_ack_has_req: assert property (!o_avs_waitrequest |-> $past(i_avs_read) || $past(i_avs_write))
        else $error("answer not caused by request");
    a_rdata_idle_zero: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0)
        else $error("read data outside answer");
    a_rdata_byte_only: assert property (o_avs_readdata[31:8] == 24'h0) else $error("read data above byte");
    a_vec_needs_en: assert property (!i_timer_irq_enable |=> !o_timer_vector_req)
        else $error("vector without enable");
    a_vec_rise_en: assert property ($rose(o_timer_vector_req) |-> $past(i_timer_irq_enable))
        else $error("vector rose while disabled");
    a_reset_quiet_out: assert property ($rose(i_resetn) |-> o_avs_waitrequest && !o_irq &&
        !o_timer_vector_req && !o_serial_rx_clock && !o_serial_tx_clock) else $error("outputs not quiet at reset");
endmodule : tmr_core_monitor

bind tmr_core tmr_core_monitor u_tmr_core_monitor (.i_clk, .i_resetn, .i_avs_read, .i_avs_write, .o_avs_readdata,
    .o_avs_waitrequest, .i_timer_irq_enable, .o_irq, .o_timer_vector_req, .o_serial_rx_clock, .o_serial_tx_clock);

// file: sim/tb_timer2_control_status_regs.sv
/* bench for tmr_core: register rows, then overflow, serial clocks, capture and counting.
   drives Avalon-MM and pins at the rising edge; checker bound separately. */
`timescale 1ns/1ps
module tb_timer2_control_status_regs;
    logic clk, rstn, rd, wr, ev, cp, en, wt, irq, vec, rxc, txc;
    logic [9:0] adr;
    logic [31:0] wd, rdat;
    logic [7:0] q, n;
    int err_total, n_checks, cyc = 0;
    logic [16:0] rows [13] = '{{1'b0, 8'hc8, 8'h00}, {1'b1, 8'hca, 8'h5a}, {1'b1, 8'hcb, 8'ha5},
        {1'b0, 8'hca, 8'h5a}, {1'b0, 8'hcb, 8'ha5}, {1'b1, 8'hcc, 8'h34}, {1'b1, 8'hcd, 8'h12},
        {1'b0, 8'hcc, 8'h34}, {1'b0, 8'hcd, 8'h12}, {1'b1, 8'h10, 8'hff}, {1'b0, 8'h10, 8'h00},
        {1'b1, 8'hc8, 8'h0a}, {1'b0, 8'hc8, 8'h0a}};
    tmr_core u_tmr_core (.i_clk(clk), .i_resetn(rstn), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
        .i_event_pin(ev), .i_capture_pin(cp), .i_timer_irq_enable(en), .o_irq(irq), .o_timer_vector_req(vec),
        .o_serial_rx_clock(rxc), .o_serial_tx_clock(txc));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= {idx, 2'b00};
        wd <= {24'h0, d};
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask : rdchk
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    initial begin
        rstn = 0; rd = 0; wr = 0; adr = 0; wd = 0; ev = 1; cp = 1; en = 1; err_total = 0; n_checks = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][16]) bus(1'b1, rows[i][15:8], rows[i][7:0]);
            else rdchk(rows[i][15:8], rows[i][7:0]);
        end
        bus(1'b1, 8'hc8, 8'h00);
        bus(1'b1, 8'hcc, 8'hfe);
        bus(1'b1, 8'hcd, 8'hff);
        bus(1'b1, 8'hd2, 8'h04);
        repeat (4) @(posedge clk);
        bus(1'b1, 8'hd3, 8'h04);
        chk({7'h0, irq}, 8'h00);
        chk({7'h0, vec}, 8'h01);
        bus(1'b1, 8'hd1, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        rdchk(8'hc8, 8'h80);
        rdchk(8'hcd, 8'ha5);
        bus(1'b0, 8'hd0, 8'h00);
        chk({7'h0, q[0]}, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, 8'hc8, 8'h00);
        rdchk(8'hc8, 8'h00);
        bus(1'b1, 8'hcc, 8'hfe);
        bus(1'b1, 8'hcd, 8'hff);
        bus(1'b1, 8'hc8, 8'h35);
        n = 0;
        repeat (8) begin
            @(posedge clk);
            if (rxc === 1'b1 && txc === 1'b1) n++;
        end
        bus(1'b1, 8'hd3, 8'h04);
        chk(n, 8'h01);
        rdchk(8'hc8, 8'h31);
        rdchk(8'hcd, 8'ha5);
        bus(1'b1, 8'hcd, 8'h3c);
        bus(1'b1, 8'hc8, 8'h09);
        cp <= 1'b0;
        repeat (8) @(posedge clk);
        rdchk(8'hc8, 8'h49);
        rdchk(8'hcb, 8'h3c);
        chk({7'h0, vec}, 8'h01);
        for (int m = 1; m < 3; m++) begin
            bus(1'b1, 8'hc9, 8'(m));
            repeat (2) @(posedge clk);
            chk({7'h0, vec}, 8'h00);
        end
        bus(1'b1, 8'hc9, 8'h00);
        en <= 1'b0;
        repeat (2) @(posedge clk);
        chk({7'h0, vec}, 8'h00);
        en <= 1'b1;
        rdchk(8'hc8, 8'h49);
        bus(1'b1, 8'hcd, 8'h00);
        bus(1'b1, 8'hc8, 8'h08);
        cp <= 1'b1;
        repeat (4) @(posedge clk);
        cp <= 1'b0;
        repeat (8) @(posedge clk);
        rdchk(8'hcd, 8'h3c);
        rdchk(8'hc8, 8'h48);
        bus(1'b1, 8'hc8, 8'h00);
        bus(1'b1, 8'hcc, 8'h00);
        bus(1'b1, 8'hc8, 8'h06);
        repeat (3) begin
            repeat (3) @(posedge clk);
            ev <= 1'b0;
            repeat (3) @(posedge clk);
            ev <= 1'b1;
        end
        repeat (8) @(posedge clk);
        bus(1'b1, 8'hc8, 8'h00);
        rdchk(8'hcc, 8'h03);
        rdchk(8'hcc, 8'h03);
        close_out();
    end
endmodule : tb_timer2_control_status_regs
